// file: shared/sbsc_params.svh
// Timings in nanoseconds, burst length, command codes and field positions for the bank state tracker.
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
`define SBSC_CLK_PERIOD_NS     10
`define SBSC_PRECHARGE_NS      20
`define SBSC_ACT_TO_COL_NS     20
`define SBSC_REFRESH_CYCLE_NS  70
`define SBSC_MODE_LOAD_NS      20
`define SBSC_BURST_LEN         8
`define SBSC_CNT_W             8
`define SBSC_AP_BIT            10
`define SBSC_ADDR_W            12
`define SBSC_CMD_NOP           4'h7
`define SBSC_CMD_ACTIVATE      4'h3
`define SBSC_CMD_READ          4'h5
`define SBSC_CMD_WRITE         4'h4
`define SBSC_CMD_BURST_STOP    4'h6
`define SBSC_CMD_PRECHARGE     4'h2
`define SBSC_CMD_REFRESH       4'h1
`define SBSC_CMD_MODE_LOAD     4'h0
`endif

// file: shared/sbsc_pkg.sv
// Types shared by the bank state tracker.
package sbsc_pkg;
  typedef enum logic [3:0] {
    SBSC_IDLE, SBSC_ACTIVATING, SBSC_ROW_ACTIVE, SBSC_READING, SBSC_WRITING,
    SBSC_READ_AP, SBSC_WRITE_AP, SBSC_PRECHARGING, SBSC_REFRESHING, SBSC_MODE_ACCESS,
    SBSC_PRECHARGE_ALL
  } sbsc_state_t;

  typedef enum logic [3:0] {
    SBSC_C_INHIBIT, SBSC_C_NOP, SBSC_C_ACTIVATE, SBSC_C_READ, SBSC_C_WRITE,
    SBSC_C_BURST_STOP, SBSC_C_PRECHARGE, SBSC_C_REFRESH, SBSC_C_MODE_LOAD
  } sbsc_cmd_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank_select_bits;
    logic [11:0] addr;
  } sbsc_pins_t;
endpackage

// file: rtl/sbsc_tracker.sv
// Per-bank state tracker and command legality checker for a four-bank SDRAM.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_params.svh"

// Notes on behaviour
// - A bank is idle after reset, after precharge and its precharge period elapsed, or after refresh or mode access.
// - Row active follows activate plus activate-to-column delay, with no burst running.
// - Reading lasts from a plain read burst until it completes or is cut short.
// - Writing lasts from a plain write burst until it completes or is cut short.
// - Precharging starts on precharge and ends after precharge period, then idle.
// - Activating starts on activate and ends after activate-to-column delay.
// - Read with auto precharge stays busy until precharge period elapsed, then idle.
// - Write with auto precharge stays busy until precharge period elapsed, then idle.
// - Refreshing lasts the refresh cycle period, then all banks idle.
// - Mode access lasts the mode-load delay, then all banks idle.
// - Precharge-all lasts the precharge period, then every bank idle.
// - Burst stop ends the most recent burst if it is a plain read or write, whichever bank owns it.
// - A single-bank precharge to an idle bank changes nothing.
// - Reads and writes are legal both with and without auto precharge.
// - Commands decode from chip select, row, column and write strobes.
// - Address bit ten selects auto precharge, or all banks on precharge.
// - An auto-precharge burst cut by another bank's burst starts precharging.
module sbsc_tracker #(
  parameter int BURST_LEN = `SBSC_BURST_LEN
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      cke,
  input  wire sbsc_pkg::sbsc_pins_t      pins,
  output logic [3:0][3:0]                bank_state,
  output logic                           all_idle,
  output logic                           illegal_cmd,
  output sbsc_pkg::sbsc_cmd_t            last_cmd
);
  localparam int CW = `SBSC_CNT_W;
  // Least times round up to whole cycles.
  localparam int PRECHARGE_PERIOD  = (`SBSC_PRECHARGE_NS + `SBSC_CLK_PERIOD_NS - 1) / `SBSC_CLK_PERIOD_NS;
  localparam int ACTIVATE_TO_COLUMN_DELAY = (`SBSC_ACT_TO_COL_NS + `SBSC_CLK_PERIOD_NS - 1) / `SBSC_CLK_PERIOD_NS;
  localparam int TRC  = (`SBSC_REFRESH_CYCLE_NS + `SBSC_CLK_PERIOD_NS - 1) / `SBSC_CLK_PERIOD_NS;
  localparam int TMRD = (`SBSC_MODE_LOAD_NS + `SBSC_CLK_PERIOD_NS - 1) / `SBSC_CLK_PERIOD_NS;

  // Pins come from another chip, so they pass two flip-flops first.
  sbsc_pkg::sbsc_pins_t pins_s1_q, pins_s2_q;
  logic                 cke_s1_q, cke_s2_q, cke_prev_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pins_s1_q  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      pins_s2_q  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      cke_s1_q   <= 1'b0;
      cke_s2_q   <= 1'b0;
      cke_prev_q <= 1'b0;
    end else begin
      pins_s1_q  <= pins;
      pins_s2_q  <= pins_s1_q;
      cke_s1_q   <= cke;
      cke_s2_q   <= cke_s1_q;
      cke_prev_q <= cke_s2_q;
    end
  end

  function automatic sbsc_pkg::sbsc_cmd_t decode(input sbsc_pkg::sbsc_pins_t p);
    if (p.cs_n) begin
      return sbsc_pkg::SBSC_C_INHIBIT;
    end
    unique case ({p.cs_n, p.ras_n, p.cas_n, p.we_n})
      `SBSC_CMD_NOP:        return sbsc_pkg::SBSC_C_NOP;
      `SBSC_CMD_ACTIVATE:   return sbsc_pkg::SBSC_C_ACTIVATE;
      `SBSC_CMD_READ:       return sbsc_pkg::SBSC_C_READ;
      `SBSC_CMD_WRITE:      return sbsc_pkg::SBSC_C_WRITE;
      `SBSC_CMD_BURST_STOP: return sbsc_pkg::SBSC_C_BURST_STOP;
      `SBSC_CMD_PRECHARGE:  return sbsc_pkg::SBSC_C_PRECHARGE;
      `SBSC_CMD_REFRESH:    return sbsc_pkg::SBSC_C_REFRESH;
      default:              return sbsc_pkg::SBSC_C_MODE_LOAD;
    endcase
  endfunction

  function automatic logic is_burst(input sbsc_pkg::sbsc_state_t s);
    return s inside {sbsc_pkg::SBSC_READING, sbsc_pkg::SBSC_WRITING,
                     sbsc_pkg::SBSC_READ_AP, sbsc_pkg::SBSC_WRITE_AP};
  endfunction

  sbsc_pkg::sbsc_state_t [3:0] st_q, st_d;
  logic [3:0][CW-1:0]          cnt_q, cnt_d;
  logic [1:0]                  recent_q, recent_d;
  logic                        illegal_q, illegal_d;
  sbsc_pkg::sbsc_cmd_t         cmd_q;
  sbsc_pkg::sbsc_cmd_t         cmd;
  logic [1:0]                  bsel;
  logic                        ap;
  logic                        every_idle;
  logic                        global_busy;
  logic                        pre_all_ok;
  logic                        active;

  always_comb begin
    cmd         = decode(pins_s2_q);
    bsel        = pins_s2_q.bank_select_bits;
    ap          = pins_s2_q.addr[`SBSC_AP_BIT];
    active      = cke_prev_q && cke_s2_q;
    every_idle  = 1'b1;
    global_busy = 1'b0;
    pre_all_ok  = 1'b1;
    for (int b = 0; b < 4; b++) begin
      every_idle  = every_idle && (st_q[b] == sbsc_pkg::SBSC_IDLE);
      pre_all_ok  = pre_all_ok && (st_q[b] inside {sbsc_pkg::SBSC_IDLE,
                    sbsc_pkg::SBSC_ROW_ACTIVE, sbsc_pkg::SBSC_READING,
                    sbsc_pkg::SBSC_WRITING});
      global_busy = global_busy || (st_q[b] inside {sbsc_pkg::SBSC_REFRESHING,
                    sbsc_pkg::SBSC_MODE_ACCESS, sbsc_pkg::SBSC_PRECHARGE_ALL});
    end
  end

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    recent_d  = recent_q;
    illegal_d = 1'b0;
    // Timed states count down and fall into their end state at zero.
    for (int b = 0; b < 4; b++) begin
      if (cnt_q[b] != '0) begin
        cnt_d[b] = cnt_q[b] - CW'(1);
      end
      if (cnt_q[b] == CW'(1)) begin
        unique case (st_q[b])
          sbsc_pkg::SBSC_ACTIVATING: st_d[b] = sbsc_pkg::SBSC_ROW_ACTIVE;
          sbsc_pkg::SBSC_READING,
          sbsc_pkg::SBSC_WRITING:    st_d[b] = sbsc_pkg::SBSC_ROW_ACTIVE;
          sbsc_pkg::SBSC_READ_AP,
          sbsc_pkg::SBSC_WRITE_AP: begin
            st_d[b]  = sbsc_pkg::SBSC_PRECHARGING;
            cnt_d[b] = CW'(PRECHARGE_PERIOD);
          end
          default:                   st_d[b] = sbsc_pkg::SBSC_IDLE;
        endcase
      end
    end
    if (active && cmd != sbsc_pkg::SBSC_C_INHIBIT && cmd != sbsc_pkg::SBSC_C_NOP) begin
      if (global_busy) begin
        illegal_d = 1'b1;
      end else begin
        unique case (cmd)
          sbsc_pkg::SBSC_C_ACTIVATE: begin
            if (st_q[bsel] == sbsc_pkg::SBSC_IDLE) begin
              st_d[bsel]  = sbsc_pkg::SBSC_ACTIVATING;
              cnt_d[bsel] = CW'(ACTIVATE_TO_COLUMN_DELAY);
            end else begin
              illegal_d = 1'b1;
            end
          end
          sbsc_pkg::SBSC_C_READ,
          sbsc_pkg::SBSC_C_WRITE: begin
            if (st_q[bsel] inside {sbsc_pkg::SBSC_ROW_ACTIVE, sbsc_pkg::SBSC_READING,
                                   sbsc_pkg::SBSC_WRITING}) begin
              // The new burst cuts off the burst running in any other bank.
              for (int b = 0; b < 4; b++) begin
                if (b != int'(bsel) && is_burst(st_q[b])) begin
                  if (st_q[b] inside {sbsc_pkg::SBSC_READ_AP, sbsc_pkg::SBSC_WRITE_AP}) begin
                    st_d[b]  = sbsc_pkg::SBSC_PRECHARGING;
                    cnt_d[b] = CW'(PRECHARGE_PERIOD);
                  end else begin
                    st_d[b]  = sbsc_pkg::SBSC_ROW_ACTIVE;
                    cnt_d[b] = '0;
                  end
                end
              end
              if (cmd == sbsc_pkg::SBSC_C_READ) begin
                st_d[bsel] = ap ? sbsc_pkg::SBSC_READ_AP : sbsc_pkg::SBSC_READING;
              end else begin
                st_d[bsel] = ap ? sbsc_pkg::SBSC_WRITE_AP : sbsc_pkg::SBSC_WRITING;
              end
              cnt_d[bsel] = CW'(BURST_LEN);
              recent_d    = bsel;
            end else begin
              illegal_d = 1'b1;
            end
          end
          sbsc_pkg::SBSC_C_BURST_STOP: begin
            if (st_q[recent_q] inside {sbsc_pkg::SBSC_READING, sbsc_pkg::SBSC_WRITING}) begin
              st_d[recent_q]  = sbsc_pkg::SBSC_ROW_ACTIVE;
              cnt_d[recent_q] = '0;
            end
          end
          sbsc_pkg::SBSC_C_PRECHARGE: begin
            // A refused precharge-all must leave every bank as it was.
            if (ap && !pre_all_ok) begin
              illegal_d = 1'b1;
            end
            for (int b = 0; b < 4; b++) begin
              if ((ap && pre_all_ok) || (!ap && b == int'(bsel))) begin
                if (st_q[b] inside {sbsc_pkg::SBSC_ROW_ACTIVE, sbsc_pkg::SBSC_READING,
                                    sbsc_pkg::SBSC_WRITING}) begin
                  st_d[b]  = ap ? sbsc_pkg::SBSC_PRECHARGE_ALL : sbsc_pkg::SBSC_PRECHARGING;
                  cnt_d[b] = CW'(PRECHARGE_PERIOD);
                end else if (st_q[b] == sbsc_pkg::SBSC_IDLE) begin
                  if (ap) begin
                    st_d[b]  = sbsc_pkg::SBSC_PRECHARGE_ALL;
                    cnt_d[b] = CW'(PRECHARGE_PERIOD);
                  end
                  // A single-bank precharge to an idle bank is ignored.
                end else begin
                  illegal_d = 1'b1;
                end
              end
            end
          end
          default: begin
            if (every_idle) begin
              for (int b = 0; b < 4; b++) begin
                st_d[b]  = (cmd == sbsc_pkg::SBSC_C_REFRESH) ? sbsc_pkg::SBSC_REFRESHING
                                                             : sbsc_pkg::SBSC_MODE_ACCESS;
                cnt_d[b] = (cmd == sbsc_pkg::SBSC_C_REFRESH) ? CW'(TRC) : CW'(TMRD);
              end
            end else begin
              illegal_d = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q      <= {4{sbsc_pkg::SBSC_IDLE}};
      cnt_q     <= '0;
      recent_q  <= 2'h0;
      illegal_q <= 1'b0;
      cmd_q     <= sbsc_pkg::SBSC_C_INHIBIT;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      recent_q  <= recent_d;
      illegal_q <= illegal_d;
      cmd_q     <= active ? cmd : sbsc_pkg::SBSC_C_INHIBIT;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bank_state[b] = st_q[b];
    end
  end
  assign all_idle    = every_idle;
  assign illegal_cmd = illegal_q;
  assign last_cmd    = cmd_q;

  // Each bank has its own timer, so interleaved work on other banks never stalls one.
  act_timing_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(st_q[0] == sbsc_pkg::SBSC_ACTIVATING) |-> ##ACTIVATE_TO_COLUMN_DELAY st_q[0] == sbsc_pkg::SBSC_ROW_ACTIVE)
    else $error("Activate did not finish on time.");
  pre_timing_a: assert property (@(posedge core_clk) disable iff (reset)
    (st_q[1] != sbsc_pkg::SBSC_PRECHARGING ##1 st_q[1] == sbsc_pkg::SBSC_PRECHARGING)
    |-> ##PRECHARGE_PERIOD st_q[1] == sbsc_pkg::SBSC_IDLE)
    else $error("Precharge did not end after its period.");
  ref_timing_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(st_q[1] == sbsc_pkg::SBSC_REFRESHING) |-> ##TRC all_idle)
    else $error("Refresh did not end after its period.");
  mode_timing_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(st_q[2] == sbsc_pkg::SBSC_MODE_ACCESS) |-> ##TMRD all_idle)
    else $error("Mode access did not end on time.");
  idle_pre_a: assert property (@(posedge core_clk) disable iff (reset)
    (active && cmd == sbsc_pkg::SBSC_C_PRECHARGE && !ap && !global_busy
     && st_q[bsel] == sbsc_pkg::SBSC_IDLE) |=> st_q[$past(bsel)] == sbsc_pkg::SBSC_IDLE)
    else $error("Idle bank changed on precharge.");
  busy_reject_a: assert property (@(posedge core_clk) disable iff (reset)
    (active && global_busy && cmd == sbsc_pkg::SBSC_C_ACTIVATE) |=> illegal_cmd)
    else $error("Command during all-bank operation not flagged.");
  ap_to_pre_a: assert property (@(posedge core_clk) disable iff (reset)
    (st_q[1] == sbsc_pkg::SBSC_READ_AP && cnt_q[1] == CW'(1))
    |=> st_q[1] == sbsc_pkg::SBSC_PRECHARGING)
    else $error("Auto precharge did not start after the burst.");
  stop_a: assert property (@(posedge core_clk) disable iff (reset)
    (active && cmd == sbsc_pkg::SBSC_C_BURST_STOP && !global_busy
     && st_q[recent_q] inside {sbsc_pkg::SBSC_READING, sbsc_pkg::SBSC_WRITING})
    |=> st_q[$past(recent_q)] == sbsc_pkg::SBSC_ROW_ACTIVE)
    else $error("Burst stop missed the recent burst.");
  cov_read_ap_c: cover property (@(posedge core_clk) st_q[1] == sbsc_pkg::SBSC_READ_AP);
  cov_refresh_c: cover property (@(posedge core_clk) st_q[0] == sbsc_pkg::SBSC_REFRESHING);
  cov_illegal_c: cover property (@(posedge core_clk) illegal_cmd);
endmodule
`default_nettype wire

// file: test/sbsc_ctrl_model.sv
// Memory controller model that drives the command pins of the bank tracker.
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl_model (
  input  wire logic                 core_clk,
  output var  sbsc_pkg::sbsc_pins_t pins
);
  integer seed = 32'h1e48;

  // Inhibit from time zero, so nothing can be registered while reset is released.
  initial pins = sbsc_pkg::sbsc_pins_t'(18'h3FFFF);

  // Pins change only at the falling edge and hold for one full cycle.
  task automatic put(input logic [3:0] code, input logic [13:0] ab);
    pins = sbsc_pkg::sbsc_pins_t'({code, ab});
    @(negedge core_clk);
  endtask

  task automatic issue(input sbsc_pkg::sbsc_cmd_t c, input logic [1:0] b, input logic ap);
    logic [31:0] r;
    logic [3:0]  code;
    r = $random(seed);
    case (c)
      sbsc_pkg::SBSC_C_ACTIVATE:   code = 4'h3;
      sbsc_pkg::SBSC_C_READ:       code = 4'h5;
      sbsc_pkg::SBSC_C_WRITE:      code = 4'h4;
      sbsc_pkg::SBSC_C_BURST_STOP: code = 4'h6;
      sbsc_pkg::SBSC_C_PRECHARGE:  code = 4'h2;
      sbsc_pkg::SBSC_C_REFRESH:    code = 4'h1;
      sbsc_pkg::SBSC_C_MODE_LOAD:  code = 4'h0;
      default:                     code = 4'h7;
    endcase
    put(code, {b, r[11], ap, r[9:0]});
  endtask

  // Between commands the bank and address lines are don't-care, so they change every
  // cycle; a tracker that wrongly looks at them cannot hide behind a stale level.
  task automatic nop(input int n);
    repeat (n) begin
      put(4'h7, 14'($random(seed)));
    end
  endtask

  task automatic noise(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = $random(seed);
      put(r[31] ? {1'b1, r[16:14]} : 4'h7, r[13:0]);
    end
  endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the bank state tracker, driven by the controller model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {
    sbsc_pkg::sbsc_cmd_t   c;
    logic                  i;
    int                    b;
    sbsc_pkg::sbsc_state_t s;
  } sbsc_exp_t;
  // A long burst leaves room to stop it well before it would end by itself.
  localparam int BL = 16;
  logic                 core_clk;
  logic                 reset;
  logic                 cke;
  wire sbsc_pkg::sbsc_pins_t pins;
  logic [3:0][3:0]      bank_state;
  logic                 all_idle;
  logic                 illegal_cmd;
  sbsc_pkg::sbsc_cmd_t  last_cmd;
  sbsc_exp_t            exp_q[$];
  int                   err_total = 0;
  int                   n_tests = 0;

  sbsc_ctrl_model sbsc_ctrl_model_i (.core_clk(core_clk), .pins(pins));
  sbsc_tracker #(.BURST_LEN(BL)) sbsc_tracker_i (
    .core_clk(core_clk), .reset(reset), .cke(cke), .pins(pins), .bank_state(bank_state),
    .all_idle(all_idle), .illegal_cmd(illegal_cmd), .last_cmd(last_cmd)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic mism(input logic [31:0] got, input logic [31:0] exp);
    err_total++;
    $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
  endtask

  task automatic nop(input int n);
    sbsc_ctrl_model_i.nop(n);
  endtask

  task automatic chk(input int b, input sbsc_pkg::sbsc_state_t s);
    n_tests++;
    if (bank_state[b] !== s) mism(bank_state[b], s);
  endtask

  // Checks that a bank holds a state for k cycles, starting at the current cycle.
  task automatic seg(input int b, input sbsc_pkg::sbsc_state_t s, input int k);
    repeat (k) begin
      chk(b, s);
      nop(1);
    end
  endtask

  task automatic run(input sbsc_pkg::sbsc_cmd_t c, input int b, input logic ap, input logic ill,
                     input int eb, input sbsc_pkg::sbsc_state_t s, input int g);
    exp_q.push_back('{c, ill, eb, s});
    sbsc_ctrl_model_i.issue(c, b[1:0], ap);
    nop(g);
  endtask

  always @(negedge core_clk) begin
    sbsc_exp_t e;
    if (!reset && last_cmd !== sbsc_pkg::SBSC_C_NOP && last_cmd !== sbsc_pkg::SBSC_C_INHIBIT) begin
      n_tests += 3;
      if (exp_q.size() == 0) begin
        mism(last_cmd, 4'hF);
      end else begin
        e = exp_q.pop_front();
        if (last_cmd !== e.c) mism(last_cmd, e.c);
        if (illegal_cmd !== e.i) mism(illegal_cmd, e.i);
        if (bank_state[e.b] !== e.s) mism(bank_state[e.b], e.s);
      end
    end
  end

  initial begin
    #100000;
    err_total++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    cke = 1'b1;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    n_tests += 3;
    if (all_idle !== 1'b1) mism(all_idle, 1);
    if (last_cmd !== sbsc_pkg::SBSC_C_INHIBIT) mism(last_cmd, 0);
    if (illegal_cmd !== 1'b0) mism(illegal_cmd, 0);
    nop(5);
    run(sbsc_pkg::SBSC_C_ACTIVATE, 1, 0, 0, 1, sbsc_pkg::SBSC_ACTIVATING, 2);
    seg(1, sbsc_pkg::SBSC_ACTIVATING, 2);
    chk(1, sbsc_pkg::SBSC_ROW_ACTIVE);
    run(sbsc_pkg::SBSC_C_WRITE, 1, 0, 0, 1, sbsc_pkg::SBSC_WRITING, 2);
    run(sbsc_pkg::SBSC_C_ACTIVATE, 2, 0, 0, 2, sbsc_pkg::SBSC_ACTIVATING, 0);
    run(sbsc_pkg::SBSC_C_ACTIVATE, 2, 0, 1, 2, sbsc_pkg::SBSC_ACTIVATING, 2);
    seg(2, sbsc_pkg::SBSC_ACTIVATING, 1);
    chk(1, sbsc_pkg::SBSC_WRITING);
    run(sbsc_pkg::SBSC_C_BURST_STOP, 3, 0, 0, 1, sbsc_pkg::SBSC_ROW_ACTIVE, 2);
    $display("test burst stop done");
    run(sbsc_pkg::SBSC_C_PRECHARGE, 1, 0, 0, 1, sbsc_pkg::SBSC_PRECHARGING, 2);
    seg(1, sbsc_pkg::SBSC_PRECHARGING, 2);
    chk(1, sbsc_pkg::SBSC_IDLE);
    for (int w = 0; w < 2; w++) begin
      run(sbsc_pkg::SBSC_C_ACTIVATE, 1, 0, 0, 1, sbsc_pkg::SBSC_ACTIVATING, 2);
      seg(1, sbsc_pkg::SBSC_ACTIVATING, 2);
      run(w ? sbsc_pkg::SBSC_C_WRITE : sbsc_pkg::SBSC_C_READ, 1, 1, 0, 1,
          w ? sbsc_pkg::SBSC_WRITE_AP : sbsc_pkg::SBSC_READ_AP, 2);
      seg(1, w ? sbsc_pkg::SBSC_WRITE_AP : sbsc_pkg::SBSC_READ_AP, BL);
      seg(1, sbsc_pkg::SBSC_PRECHARGING, 2);
      chk(1, sbsc_pkg::SBSC_IDLE);
    end
    run(sbsc_pkg::SBSC_C_PRECHARGE, 0, 0, 0, 0, sbsc_pkg::SBSC_IDLE, 2);
    $display("test auto precharge done");
    run(sbsc_pkg::SBSC_C_ACTIVATE, 3, 0, 0, 3, sbsc_pkg::SBSC_ACTIVATING, 2);
    seg(3, sbsc_pkg::SBSC_ACTIVATING, 2);
    run(sbsc_pkg::SBSC_C_WRITE, 3, 1, 0, 3, sbsc_pkg::SBSC_WRITE_AP, 2);
    run(sbsc_pkg::SBSC_C_READ, 2, 0, 0, 3, sbsc_pkg::SBSC_PRECHARGING, 2);
    chk(2, sbsc_pkg::SBSC_READING);
    seg(3, sbsc_pkg::SBSC_PRECHARGING, 2);
    chk(3, sbsc_pkg::SBSC_IDLE);
    run(sbsc_pkg::SBSC_C_PRECHARGE, 0, 1, 0, 2, sbsc_pkg::SBSC_PRECHARGE_ALL, 2);
    chk(0, sbsc_pkg::SBSC_PRECHARGE_ALL);
    seg(2, sbsc_pkg::SBSC_PRECHARGE_ALL, 2);
    n_tests++;
    if (all_idle !== 1'b1) mism(all_idle, 1);
    $display("test concurrent precharge done");
    run(sbsc_pkg::SBSC_C_REFRESH, 0, 0, 0, 0, sbsc_pkg::SBSC_REFRESHING, 2);
    run(sbsc_pkg::SBSC_C_ACTIVATE, 0, 0, 1, 0, sbsc_pkg::SBSC_REFRESHING, 2);
    seg(0, sbsc_pkg::SBSC_REFRESHING, 4);
    chk(0, sbsc_pkg::SBSC_IDLE);
    run(sbsc_pkg::SBSC_C_MODE_LOAD, 0, 0, 0, 0, sbsc_pkg::SBSC_MODE_ACCESS, 2);
    seg(0, sbsc_pkg::SBSC_MODE_ACCESS, 2);
    chk(0, sbsc_pkg::SBSC_IDLE);
    run(sbsc_pkg::SBSC_C_ACTIVATE, 0, 0, 0, 0, sbsc_pkg::SBSC_ACTIVATING, 2);
    seg(0, sbsc_pkg::SBSC_ACTIVATING, 2);
    run(sbsc_pkg::SBSC_C_REFRESH, 0, 0, 1, 0, sbsc_pkg::SBSC_ROW_ACTIVE, 2);
    run(sbsc_pkg::SBSC_C_MODE_LOAD, 0, 0, 1, 0, sbsc_pkg::SBSC_ROW_ACTIVE, 2);
    $display("test all bank operations done");
    cke = 1'b0;
    nop(3);
    sbsc_ctrl_model_i.issue(sbsc_pkg::SBSC_C_ACTIVATE, 2'h1, 1'b0);
    nop(3);
    n_tests++;
    if (last_cmd !== sbsc_pkg::SBSC_C_INHIBIT) mism(last_cmd, 0);
    chk(1, sbsc_pkg::SBSC_IDLE);
    cke = 1'b1;
    nop(5);
    $display("test clock enable done");
    sbsc_ctrl_model_i.noise(24);
    for (int b = 0; b < 4; b++) chk(b, b == 0 ? sbsc_pkg::SBSC_ROW_ACTIVE : sbsc_pkg::SBSC_IDLE);
    $display("test noise done");
    nop(4);
    n_tests++;
    if (exp_q.size() != 0) mism(exp_q.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
